// [rtl/hec_top.sv]
// Event counter box: four 48-bit counters with box control, status and
// per-counter control, reached over a plain register port.
// Assumes event inputs come from logic on mclk; reset is synchronous.
//
// Behaviour
// - Writing 1 to box control bit 8 freezes all counters, holding values.
// - Writing 1 to box control bit 1 clears all counter data to zero.
// - Writing 1 to box control bit 0 clears all counter control registers.
// - A counter overflow with control bit 20 set sets its flag in status bits 3:0.
// - Status overflow flags clear on write of 1; writing 0 keeps them.
// - Control bits 31:24 hold a threshold compared with the selected event's per-cycle value.
// - A counter increments only while control bit 22 is set.
// - With bit 20 set, overflow sets status flag and sends a message.
// - Edge mode bit 18 counts zero-to-one transitions of the qualified event.
// - Without edge mode, add the selected event's value each cycle; with a threshold, add 1 per qualifying cycle.
// - Writing 1 to control bit 17 clears that counter's data.
// - Writing 1 to control bit 16 clears the selected event's occupancy accumulator.
// - Occupancy accumulators never decrement below zero.
// - Control bits 15:8 select contributing subevents.
// - Control bits 7:0 select the monitored event.
// - Four 48-bit counters, each with its own control register.
// - Overflow is a carry out of counter bit 47.
// - After overflow the counter wraps and keeps counting.
`include "hec_defs.svh"

module hec_top #(
    parameter logic [3:0] BOX_ID = 4'h1 // Arbitrary box identifier
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic [3:0][7:0] sub_events,
    input wire logic [1:0] q_insert,
    input wire logic [1:0] q_remove,
    output hec_pkg::hec_ovf_msg_t ovf_msg,
    output logic frozen
);
    // Per-counter state
    hec_pkg::hec_ctl_t ctl_reg [4];
    hec_pkg::hec_ctl_t ctl_next [4];
    logic [47:0] cnt_reg [4];
    logic [47:0] cnt_next [4];
    logic [3:0] qual_prev_reg;
    logic [3:0] qual_prev_next;
    logic [3:0] carry;
    // Box state
    logic frozen_reg;
    logic frozen_next;
    logic [3:0] overflow_flags_reg;
    logic [3:0] overflow_flags_next;
    logic [7:0] occ_reg [2];
    logic [7:0] occ_next [2];
    logic [1:0] occ_clr;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    hec_pkg::hec_ovf_msg_t ovf_msg_reg;
    hec_pkg::hec_ovf_msg_t ovf_msg_next;
    // Decoded writes
    logic box_wr;
    logic status_wr;
    logic [3:0] ctl_wr;
    logic [3:0] lo_wr;
    logic [3:0] hi_wr;
    logic [3:0] ctl_sel;
    logic [3:0] lo_sel;
    logic [3:0] hi_sel;
    // Counters reporting a wrap this cycle
    logic [3:0] ovf_set;

    // Number of set bits in a subevent vector
    function automatic logic [7:0] popcnt8(input logic [7:0] v);
        logic [7:0] n;
        n = 8'h00;
        for (int b = 0; b < 8; b++) begin
            n = n + {7'h00, v[b]};
        end
        return n;
    endfunction

    // Address decode of writes
    always_comb begin
        box_wr = wr_en && (addr == `HEC_OFF_BOXCTL);
        status_wr = wr_en && (addr == `HEC_OFF_STATUS);
        for (int k = 0; k < `HEC_NUM_CTR; k++) begin
            ctl_sel[k] = (addr == `HEC_OFF_CTL0 + 8'(4 * k));
            lo_sel[k] = (addr == `HEC_OFF_CTR0 + 8'(8 * k));
            hi_sel[k] = (addr == `HEC_OFF_CTR0 + 8'(8 * k + 4));
            ctl_wr[k] = wr_en && ctl_sel[k];
            lo_wr[k] = wr_en && lo_sel[k];
            hi_wr[k] = wr_en && hi_sel[k];
        end
    end

    // Box freeze level, kept until the next box control write
    always_comb begin
        frozen_next = frozen_reg;
        if (box_wr) begin
            frozen_next = wr_data[`HEC_BOX_FRZ];
        end
    end

    // Occupancy clear requests from control writes naming a queue event
    always_comb begin
        occ_clr = 2'b00;
        for (int k = 0; k < `HEC_NUM_CTR; k++) begin
            if (ctl_wr[k] && wr_data[`HEC_CTL_QCLR] && wr_data[7:1] == `HEC_QEV_BASE) begin
                occ_clr[wr_data[0]] = 1'b1;
            end
        end
    end

    // Queue occupancy accumulators, saturating at both ends
    generate
        for (genvar q = 0; q < `HEC_NUM_QUEUE; q++) begin : g_occ
            always_comb begin
                occ_next[q] = occ_reg[q];
                if (occ_clr[q]) begin
                    occ_next[q] = 8'h00;
                end else if (q_insert[q] && !q_remove[q] && occ_reg[q] != `HEC_OCC_MAX) begin
                    occ_next[q] = occ_reg[q] + 8'h01;
                end else if (q_remove[q] && !q_insert[q] && occ_reg[q] != 8'h00) begin
                    occ_next[q] = occ_reg[q] - 8'h01;
                end
            end
            always_ff @(posedge mclk) begin
                if (rst) begin
                    occ_reg[q] <= 8'h00;
                end else begin
                    occ_reg[q] <= occ_next[q];
                end
            end
        end
    endgenerate

    // One counter and its control register per lane
    generate
        for (genvar i = 0; i < `HEC_NUM_CTR; i++) begin : g_ctr
            logic [7:0] raw;
            logic qual;
            logic [7:0] amt;
            logic [48:0] sum;
            logic counting;
            logic loaded;

            // Event source: masked subevents or a queue occupancy
            always_comb begin
                raw = 8'h00;
                if (ctl_reg[i].event_choice < 8'(`HEC_NUM_SUBEV)) begin
                    raw = popcnt8(sub_events[ctl_reg[i].event_choice[1:0]] & ctl_reg[i].umask);
                end else if (ctl_reg[i].event_choice[7:1] == `HEC_QEV_BASE) begin
                    raw = occ_reg[ctl_reg[i].event_choice[0]];
                end
            end

            // Threshold stage first, edge detection after it
            always_comb begin
                if (ctl_reg[i].thresh == 8'h00) begin
                    qual = (raw != 8'h00);
                end else begin
                    qual = (raw >= ctl_reg[i].thresh);
                end
                if (ctl_reg[i].edge_mode) begin
                    amt = {7'h00, qual && !qual_prev_reg[i]};
                end else if (ctl_reg[i].thresh == 8'h00) begin
                    amt = raw;
                end else begin
                    amt = {7'h00, qual};
                end
                qual_prev_next[i] = qual;
            end

            // Counter next value; a clear or data write beats counting, so it never reports a wrap
            always_comb begin
                counting = ctl_reg[i].enable && !frozen_reg;
                loaded = (box_wr && wr_data[`HEC_BOX_RST_CTRS]) || (ctl_wr[i] && wr_data[`HEC_CTL_CLR])
                    || lo_wr[i] || hi_wr[i];
                sum = {1'b0, cnt_reg[i]} + {41'h0, amt};
                carry[i] = counting && !loaded && sum[48];
                cnt_next[i] = cnt_reg[i];
                if (box_wr && wr_data[`HEC_BOX_RST_CTRS]) begin
                    cnt_next[i] = `HEC_CNT_RESET;
                end else if (ctl_wr[i] && wr_data[`HEC_CTL_CLR]) begin
                    cnt_next[i] = `HEC_CNT_RESET;
                end else if (lo_wr[i]) begin
                    cnt_next[i] = {cnt_reg[i][47:32], wr_data};
                end else if (hi_wr[i]) begin
                    cnt_next[i] = {wr_data[15:0], cnt_reg[i][31:0]};
                end else if (counting) begin
                    cnt_next[i] = sum[47:0];
                end
            end

            // Control register next value
            always_comb begin
                ctl_next[i] = ctl_reg[i];
                if (box_wr && wr_data[`HEC_BOX_RST_CTRL]) begin
                    ctl_next[i] = `HEC_CTL_RESET;
                end else if (ctl_wr[i]) begin
                    ctl_next[i] = wr_data & `HEC_CTL_STORE_MASK;
                end
            end
            always_ff @(posedge mclk) begin
                if (rst) begin
                    cnt_reg[i] <= `HEC_CNT_RESET;
                    ctl_reg[i] <= `HEC_CTL_RESET;
                    qual_prev_reg[i] <= 1'b0;
                end else begin
                    cnt_reg[i] <= cnt_next[i];
                    ctl_reg[i] <= ctl_next[i];
                    qual_prev_reg[i] <= qual_prev_next[i];
                end
            end
        end
    endgenerate

    // Counters that wrapped with reporting switched on
    always_comb begin
        ovf_set = 4'h0;
        for (int k = 0; k < `HEC_NUM_CTR; k++) begin
            ovf_set[k] = carry[k] && ctl_reg[k].overflow_report_enable;
        end
    end

    // Overflow flags; a new overflow wins over a same-cycle clear
    always_comb begin
        overflow_flags_next = overflow_flags_reg;
        if (status_wr) begin
            overflow_flags_next = overflow_flags_reg & ~wr_data[3:0];
        end
        overflow_flags_next = overflow_flags_next | ovf_set;
    end

    // Message toward the monitor unit, one cycle per wrap event
    always_comb begin
        ovf_msg_next.valid = (ovf_set != 4'h0);
        ovf_msg_next.box_id = BOX_ID;
        ovf_msg_next.ctr_mask = ovf_set;
    end

    // Read multiplexer; unmapped and write-only addresses read zero
    always_comb begin
        rd_data_next = 32'h00000000;
        if (rd_en) begin
            if (addr == `HEC_OFF_STATUS) begin
                rd_data_next = {28'h0000000, overflow_flags_reg};
            end
            for (int k = 0; k < `HEC_NUM_CTR; k++) begin
                if (ctl_sel[k]) begin
                    rd_data_next = ctl_reg[k];
                end
                if (lo_sel[k]) begin
                    rd_data_next = cnt_reg[k][31:0];
                end
                if (hi_sel[k]) begin
                    rd_data_next = {16'h0000, cnt_reg[k][47:32]};
                end
            end
        end
    end

    // Freeze level register
    always_ff @(posedge mclk) begin
        if (rst) begin
            frozen_reg <= 1'b0;
        end else begin
            frozen_reg <= frozen_next;
        end
    end

    // Overflow flag register
    always_ff @(posedge mclk) begin
        if (rst) begin
            overflow_flags_reg <= `HEC_STATUS_RESET;
        end else begin
            overflow_flags_reg <= overflow_flags_next;
        end
    end

    // Read data register, zero outside the answer cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_reg <= 32'h00000000;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Overflow message register
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovf_msg_reg <= '0;
        end else begin
            ovf_msg_reg <= ovf_msg_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign ovf_msg = ovf_msg_reg;
    assign frozen = frozen_reg;
endmodule

// [rtl/hec_defs.svh]
// Offsets, field positions and reset values of the event counter box.
// Assumes byte addressing on an 8-bit register port, one 32-bit word per register.
`ifndef HEC_DEFS_SVH
`define HEC_DEFS_SVH
`define HEC_OFF_STATUS 8'hF8
`define HEC_OFF_BOXCTL 8'hF4
`define HEC_OFF_CTL0 8'hD8
`define HEC_OFF_CTL3 8'hE4
`define HEC_OFF_CTR0 8'hA0
`define HEC_OFF_CTR3_HI 8'hBC
`define HEC_BOX_FRZ 8
`define HEC_BOX_RST_CTRS 1
`define HEC_BOX_RST_CTRL 0
`define HEC_CTL_CLR 17
`define HEC_CTL_QCLR 16
`define HEC_CTL_STORE_MASK 32'hFF54FFFF
`define HEC_CTL_RESET 32'h00000000
`define HEC_STATUS_RESET 4'h0
`define HEC_CNT_RESET 48'h000000000000
`define HEC_NUM_CTR 4
`define HEC_NUM_SUBEV 4
`define HEC_NUM_QUEUE 2
`define HEC_QEV_BASE 7'h10
`define HEC_OCC_MAX 8'hFF
`endif

// [rtl/hec_pkg.sv]
// Types shared by the event counter box and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package hec_pkg;
    // Layout of one counter control register
    typedef struct packed {
        logic [7:0] thresh;
        logic rsv23;
        logic enable;
        logic rsv21;
        logic overflow_report_enable;
        logic ig19;
        logic edge_mode;
        logic clr;
        logic qclr;
        logic [7:0] umask;
        logic [7:0] event_choice;
    } hec_ctl_t;
    // Overflow message toward the global monitor unit
    typedef struct packed {
        logic valid;
        logic [3:0] box_id;
        logic [3:0] ctr_mask;
    } hec_ovf_msg_t;
endpackage

// [test/hec_top_assertions.sv]
// Checker of port relations of the event counter box.
// Assumes it is bound into hec_top, one clock mclk, synchronous reset rst.
`include "hec_defs.svh"
module hec_top_chk #(
    parameter logic [3:0] BOX_ID = 4'h1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire hec_pkg::hec_ovf_msg_t ovf_msg,
    input wire logic frozen
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Freeze follows box control writes only
    frz_set_a: assert property (wr_en && addr == `HEC_OFF_BOXCTL && wr_data[8] |=> frozen) else $error("no freeze");
    frz_clr_a: assert property (wr_en && addr == `HEC_OFF_BOXCTL && !wr_data[8] |=> !frozen) else $error("no thaw");
    frz_hold_a: assert property (!(wr_en && addr == `HEC_OFF_BOXCTL) |=> $stable(frozen)) else $error("freeze moved");
    // Overflow message shape
    msg_pulse_a: assert property (ovf_msg.valid |=> !ovf_msg.valid) else $error("message too long");
    msg_box_a: assert property (ovf_msg.valid |-> ovf_msg.box_id == BOX_ID && ovf_msg.ctr_mask != 4'h0)
        else $error("bad message");
    msg_frz_a: assert property (ovf_msg.valid |-> !$past(frozen)) else $error("message while frozen");
    // Read-back of write-only and ignored bits
    box_wo_a: assert property (rd_en && addr == `HEC_OFF_BOXCTL |=> rd_data == 32'h0) else $error("box reads");
    ctl_wo_a: assert property (rd_en && addr == `HEC_OFF_CTL0 |=> (rd_data & ~`HEC_CTL_STORE_MASK) == 32'h0)
        else $error("control bits leak");
    stat_rsv_a: assert property (rd_en && addr == `HEC_OFF_STATUS |=> rd_data[31:4] == 28'h0)
        else $error("status upper set");
    cover property (ovf_msg.valid);
    cover property (frozen ##1 !frozen);
    cover property (rd_en && addr == `HEC_OFF_STATUS ##1 rd_data != 32'h0);
endmodule
bind hec_top hec_top_chk #(.BOX_ID(BOX_ID)) u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ovf_msg(ovf_msg), .frozen(frozen));

// [test/hec_gmu_model.sv]
// Model of the global monitor unit taking overflow messages.
// Assumes messages arrive on mclk as one-cycle pulses.
module hec_gmu_model (
    input wire logic mclk,
    input wire logic rst,
    input wire hec_pkg::hec_ovf_msg_t msg,
    output logic [31:0] n_msg,
    output logic [3:0] mask_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Tally pulses and gather reporting counters
    always_ff @(posedge mclk) begin
        if (rst) begin
            n_msg <= 32'h0;
            mask_seen <= 4'h0;
        end else if (msg.valid) begin
            n_msg <= n_msg + 32'h1;
            mask_seen <= mask_seen | msg.ctr_mask;
        end
    end
endmodule

// [test/hec_top_tb.sv]
// Self-checking bench for the event counter box with a monitor model.
// Assumes the register map of the box header and a 25 MHz mclk.
`include "hec_defs.svh"
module hec_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, frozen;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0, rd_data, n_msg, got;
    logic [3:0][7:0] sub_events = 32'h0000FF00;
    logic [1:0] q_insert = 2'h0, q_remove = 2'h0;
    logic [3:0] mask_seen;
    hec_pkg::hec_ovf_msg_t ovf_msg;
    int n_fail = 0, n_compared = 0, cycles = 0;
    hec_top u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .sub_events(sub_events), .q_insert(q_insert), .q_remove(q_remove),
        .ovf_msg(ovf_msg), .frozen(frozen));
    hec_gmu_model u_gmu (.mclk(mclk), .rst(rst), .msg(ovf_msg), .n_msg(n_msg), .mask_seen(mask_seen));
    // Clock and hang guard
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // Read, then compare the word of the following cycle
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 got = rd_data;
        chk(got, e, m);
    endtask
    // Event 0 subevents held at v for n cycles
    task automatic ev(input logic [7:0] v, input int n);
        @(posedge mclk);
        sub_events[0] <= v;
        repeat (n) @(posedge mclk);
        sub_events[0] <= 8'h00;
    endtask
    // Queue 0 insert or remove pulses held for n cycles
    task automatic qp(input logic ins, input logic rem, input int n);
        @(posedge mclk);
        q_insert[0] <= ins;
        q_remove[0] <= rem;
        repeat (n) @(posedge mclk);
        q_insert[0] <= 1'b0;
        q_remove[0] <= 1'b0;
    endtask
    task automatic t_reset();
        rchk(`HEC_OFF_STATUS, 32'h0, "status reset");
        rchk(`HEC_OFF_CTL0, 32'h0, "control reset");
        chk({31'h0, frozen}, 32'h0, "not frozen");
        $display("test reset done");
    endtask
    // Counter 1 adds queue 0 occupancy each cycle
    task automatic t_occ();
        qp(1'b1, 1'b0, 3);
        wr(`HEC_OFF_CTL0 + 8'h04, 32'h00410020);
        qp(1'b0, 1'b1, 2);
        rchk(`HEC_OFF_CTR0 + 8'h08, 32'h0, "occupancy cleared");
        qp(1'b1, 1'b0, 1);
        wr(`HEC_OFF_BOXCTL, 32'h00030100);
        rchk(`HEC_OFF_CTR0 + 8'h08, 32'h2, "occupancy floor");
        $display("test occupancy done");
    endtask
    task automatic t_count();
        wr(`HEC_OFF_CTL0, 32'h00400100);
        ev(8'h03, 5);
        rchk(`HEC_OFF_CTR0, 32'h5, "level count");
        wr(`HEC_OFF_CTL0, 32'h00000100);
        ev(8'h01, 4);
        rchk(`HEC_OFF_CTR0, 32'h5, "disabled");
        $display("test count done");
    endtask
    task automatic t_edge();
        wr(`HEC_OFF_CTL0, 32'h0246FF00);
        ev(8'h07, 3);
        ev(8'h03, 2);
        ev(8'h01, 2);
        rchk(`HEC_OFF_CTR0, 32'h2, "edge count");
        wr(`HEC_OFF_CTL0, 32'h0242FF00);
        ev(8'h07, 3);
        ev(8'h01, 2);
        rchk(`HEC_OFF_CTR0, 32'h3, "threshold");
        rchk(`HEC_OFF_CTL0, 32'h0240FF00, "control");
        $display("test edge done");
    endtask
    task automatic t_freeze();
        wr(`HEC_OFF_BOXCTL, 32'h00030100);
        ev(8'h07, 4);
        rchk(`HEC_OFF_CTR0, 32'h3, "frozen");
        chk({31'h0, frozen}, 32'h1, "freeze level");
        wr(`HEC_OFF_BOXCTL, 32'h00030000);
        ev(8'h07, 4);
        rchk(`HEC_OFF_CTR0, 32'h7, "thawed");
        chk({31'h0, frozen}, 32'h0, "thaw level");
        $display("test freeze done");
    endtask
    task automatic t_ovf();
        wr(`HEC_OFF_CTR0, 32'hFFFFFFFF);
        wr(`HEC_OFF_CTR0 + 8'h04, 32'h0000FFFF);
        wr(`HEC_OFF_CTL0, 32'h00500100);
        ev(8'h01, 2);
        rchk(`HEC_OFF_CTR0, 32'h1, "wrap low");
        rchk(`HEC_OFF_CTR0 + 8'h04, 32'h0, "wrap high");
        rchk(`HEC_OFF_STATUS, 32'h1, "flag");
        chk(n_msg, 32'h1, "messages");
        chk({28'h0, mask_seen}, 32'h1, "mask");
        wr(`HEC_OFF_STATUS, 32'h0);
        rchk(`HEC_OFF_STATUS, 32'h1, "kept");
        wr(`HEC_OFF_STATUS, 32'h1);
        rchk(`HEC_OFF_STATUS, 32'h0, "cleared");
        $display("test overflow done");
    endtask
    task automatic t_clear();
        wr(`HEC_OFF_BOXCTL, 32'h00030002);
        rchk(`HEC_OFF_CTR0, 32'h0, "counters");
        wr(`HEC_OFF_BOXCTL, 32'h00030001);
        rchk(`HEC_OFF_CTL0, 32'h0, "controls");
        rchk(8'h10, 32'h0, "unmapped");
        $display("test clear done");
    endtask
    task automatic finish_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_count();
        t_edge();
        t_freeze();
        t_ovf();
        t_clear();
        t_occ();
        finish_test();
    end
endmodule
